/* design/bcd_unit_pkg.sv */
`default_nettype none
package bcd_unit_pkg;

  // widths
  localparam int WORD_W     = 16;
  localparam int ACC_W      = 32;
  localparam int DIG_W      = 4;
  localparam int ACC_DIGITS = 8;
  localparam int BIN_W      = 27;
  localparam int PROD_W     = 54;
  localparam int PROD_DIGITS = 16;
  localparam int REG_AW     = 4;
  localparam int REG_DW     = 32;
  localparam int EV_W       = 3;

  // register offsets
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h0;
  localparam logic [REG_AW-1:0] REG_MASK   = 4'h4;
  localparam logic [REG_AW-1:0] REG_FLAGS  = 4'h8;
  localparam logic [REG_AW-1:0] REG_ACC    = 4'hc;

  // status and mask bit positions
  localparam int EV_DONE = 0;
  localparam int EV_INV  = 1;
  localparam int EV_OVF  = 2;

  // reset values
  localparam logic [EV_W-1:0]  STATUS_RESET = 3'h0;
  localparam logic [EV_W-1:0]  MASK_RESET   = 3'h0;
  localparam logic [ACC_W-1:0] ACC_RESET    = 32'h0;

  typedef enum logic [2:0] {
    op_mul_word, op_mul_long, op_div_word, op_div_long,
    op_inc_bcd, op_dec_bcd, op_inc_bin
  } op_t;

  typedef struct packed {
    logic              valid;
    logic              rung;
    op_t               op;
    logic              use_const;
    logic [WORD_W-1:0] konst;
    logic [WORD_W-1:0] addr;
  } cmd_t;

  typedef struct packed {
    logic ovf;
    logic inv;
    logic neg;
    logic zero;
  } flags_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
  } reg_req_t;

  // every nibble a decimal digit
  function automatic logic is_bcd(input logic [ACC_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ACC_DIGITS; i++) begin
      if (v[DIG_W*i +: DIG_W] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : is_bcd

  function automatic logic [BIN_W-1:0] bcd_to_bin(input logic [ACC_W-1:0] v);
    logic [BIN_W-1:0] r;
    r = '0;
    for (int i = ACC_DIGITS - 1; i >= 0; i--) begin
      r = BIN_W'(r * 27'd10 + BIN_W'(v[DIG_W*i +: DIG_W]));
    end
    return r;
  endfunction : bcd_to_bin

  // four-digit decimal step by one, wrapping at 9999 and 0000
  function automatic logic [WORD_W-1:0] bcd_step(input logic [WORD_W-1:0] v, input logic down);
    logic [WORD_W-1:0] r;
    logic              carry;
    r     = v;
    carry = 1'b1;
    for (int i = 0; i < WORD_W / DIG_W; i++) begin
      if (carry) begin
        if (down) begin
          carry = (r[DIG_W*i +: DIG_W] == 4'h0);
          r[DIG_W*i +: DIG_W] = carry ? 4'h9 : 4'(r[DIG_W*i +: DIG_W] - 4'h1);
        end else begin
          carry = (r[DIG_W*i +: DIG_W] == 4'h9);
          r[DIG_W*i +: DIG_W] = carry ? 4'h0 : 4'(r[DIG_W*i +: DIG_W] + 4'h1);
        end
      end
    end
    return r;
  endfunction : bcd_step

endpackage : bcd_unit_pkg
`default_nettype wire

/* design/bin_to_bcd.sv */
`default_nettype none
module bin_to_bcd #(
  parameter int BITS   = 54,
  parameter int DIGITS = 16
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  // conversion request
  input  wire logic                  i_start,
  input  wire logic [BITS-1:0]       i_bin,
  // result
  output logic                       o_done,
  output logic [4*DIGITS-1:0]        o_bcd
);
  localparam int CW = $clog2(BITS + 1);

  logic [BITS-1:0]     bin;
  logic [CW-1:0]       cnt;
  logic [4*DIGITS-1:0] adj;

  // add three to every digit of five or more before each shift
  always_comb begin
    adj = o_bcd;
    for (int i = 0; i < DIGITS; i++) begin
      if (o_bcd[4*i +: 4] > 4'h4) adj[4*i +: 4] = 4'(o_bcd[4*i +: 4] + 4'h3);
    end
  end

  // one bit per cycle keeps the adder small at the cost of latency
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bin    <= '0;
      cnt    <= '0;
      o_bcd  <= '0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_start) begin
        bin   <= i_bin;
        cnt   <= CW'(BITS);
        o_bcd <= '0;
      end else if (cnt != '0) begin
        o_bcd  <= {adj[4*DIGITS-2:0], bin[BITS-1]};
        bin    <= {bin[BITS-2:0], 1'b0};
        cnt    <= CW'(cnt - 1'b1);
        o_done <= (cnt == CW'(1));
      end
    end
  end
endmodule : bin_to_bcd
`default_nettype wire

/* design/bcd_mul_div_incdec_unit.sv */
// Operation
// RULE_01: the word multiply takes the low four digits of the accumulator times a memory or constant operand and leaves up to eight digits in the accumulator.
// RULE_02: the long multiply takes the eight-digit accumulator times an eight-digit operand read from two consecutive memory words.
// RULE_03: the long multiply keeps the low eight product digits in the accumulator and pushes the high digits onto the stack.
// RULE_04: the word divide divides the accumulator by a memory or constant operand, quotient to the accumulator and remainder to the first stack place.
// RULE_05: the long divide divides the accumulator by a two-word memory divisor, quotient to the accumulator and remainder to the first stack place.
// RULE_06: the sequencer never gives a constant as divisor of the long divide; only the two-word memory operand is used.
// RULE_07: the decimal increment reads the addressed word, adds one in decimal and writes it back to the same word.
// RULE_08: the decimal decrement reads the addressed word, subtracts one in decimal and writes it back to the same word.
// RULE_09: the binary increment adds one in binary to the addressed word and writes it back there.
// RULE_10: the zero flag is set whenever a multiply, divide, increment or decrement leaves a zero result.
// RULE_11: the negative flag is set whenever a multiply or divide leaves a negative accumulator.
// RULE_12: the invalid-digit flag is set whenever a decimal operation meets a nibble above nine.
// RULE_13: a divide sets the overflow flag when the operand is beyond what the accumulator can process.
// RULE_14: a flag value holds only until the next instruction driving that flag, so users sample it before then.
// RULE_15: flags not tied to the running instruction stay unchanged.
// RULE_16: an instruction runs only when its rung condition is true; otherwise nothing changes.
// RULE_17: the binary increment never drives the invalid-digit flag and updates only the zero flag.
//
// The address map and the address-and-strobe port were decided locally.
`default_nettype none
module bcd_mul_div_incdec_unit (
  // clock, reset, enable
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_ce,
  // instruction from the sequencer
  input  wire bcd_unit_pkg::cmd_t            i_cmd,
  output logic                               o_busy,
  output logic                               o_done,
  // accumulator load from the sequencer
  input  wire logic                          i_acc_load,
  input  wire logic [bcd_unit_pkg::ACC_W-1:0] i_acc_wdata,
  // accumulator, stack and flags
  output logic [bcd_unit_pkg::ACC_W-1:0]     o_acc,
  output logic [bcd_unit_pkg::ACC_W-1:0]     o_stack_top,
  output logic                               o_stack_push,
  output bcd_unit_pkg::flags_t               o_flags,
  // word memory
  output logic                               o_mem_rd,
  output logic                               o_mem_wr,
  output logic [bcd_unit_pkg::WORD_W-1:0]    o_mem_addr,
  output logic [bcd_unit_pkg::WORD_W-1:0]    o_mem_wdata,
  input  wire logic [bcd_unit_pkg::WORD_W-1:0] i_mem_rdata,
  // register port and interrupt
  input  wire bcd_unit_pkg::reg_req_t        i_reg,
  output logic [bcd_unit_pkg::REG_DW-1:0]    o_reg_rdata,
  output logic                               o_irq
);
  import bcd_unit_pkg::*;

  typedef enum logic [2:0] {
    st_idle, st_fetch_lo, st_fetch_hi, st_calc, st_convert, st_finish
  } state_t;

  state_t                  state;
  op_t                     op_r;
  logic [WORD_W-1:0]       addr_r;
  logic [ACC_W-1:0]        opnd;
  logic [WORD_W-1:0]       res_word;
  logic [PROD_W-1:0]       conv_bin;
  logic [BIN_W-1:0]        rem_bin;
  logic                    conv_start;
  logic                    bad_bcd;
  logic                    div_zero;
  logic                    ran;
  logic [EV_W-1:0]         status;
  logic [EV_W-1:0]         mask;
  logic [EV_W-1:0]         next_status;
  logic [EV_W-1:0]         next_mask;
  logic [4*PROD_DIGITS-1:0] prod_bcd;
  logic [ACC_W-1:0]        rem_bcd;
  logic                    wide_done;
  logic [ACC_W-1:0]        a_val;
  logic [BIN_W-1:0]        a_bin;
  logic [BIN_W-1:0]        b_bin;
  logic                    bcd_ok;
  logic                    is_div;
  logic                    is_mem_op;
  logic                    is_long;
  logic                    ok_result;
  logic                    accept;
  logic                    fin;

  assign is_div    = (op_r == op_div_word) || (op_r == op_div_long);
  assign is_mem_op = (op_r == op_inc_bcd) || (op_r == op_dec_bcd) || (op_r == op_inc_bin);
  assign is_long   = (op_r == op_mul_long) || (op_r == op_div_long);
  assign ok_result = !bad_bcd && !div_zero;
  assign accept    = (state == st_idle) && i_cmd.valid;
  assign fin       = (state == st_finish);

  // operand decode for the calc cycle
  always_comb begin
    a_val  = (op_r == op_mul_word) ? {16'h0, o_acc[WORD_W-1:0]} : o_acc; // RULE_01
    a_bin  = bcd_to_bin(a_val);
    b_bin  = bcd_to_bin(opnd);
    bcd_ok = (op_r == op_inc_bin) || (is_bcd(opnd) && (is_mem_op || is_bcd(a_val))); // RULE_12
  end

  // sequencing; a command while busy is ignored
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state      <= st_idle;
      op_r       <= op_mul_word;
      addr_r     <= '0;
      ran        <= 1'b0;
      conv_start <= 1'b0;
      o_busy     <= 1'b0;
    end else if (i_ce) begin
      conv_start <= 1'b0;
      case (state)
        st_idle: begin
          if (accept) begin
            op_r   <= i_cmd.op;
            addr_r <= i_cmd.addr;
            ran    <= i_cmd.rung;
            if (i_cmd.rung) begin // RULE_16
              o_busy <= 1'b1;
              // constant only for word multiply and word divide
              if (i_cmd.use_const && (i_cmd.op == op_mul_word || i_cmd.op == op_div_word)) begin
                state <= st_calc;
              end else begin
                state <= st_fetch_lo; // RULE_06
              end
            end
          end
        end
        st_fetch_lo: state <= is_long ? st_fetch_hi : st_calc; // RULE_02
        st_fetch_hi: state <= st_calc;
        st_calc: begin
          if (!is_mem_op && bcd_ok && !(is_div && b_bin == '0)) begin
            conv_start <= 1'b1;
            state      <= st_convert;
          end else begin
            state <= st_finish;
          end
        end
        st_convert: if (wide_done) state <= st_finish;
        st_finish: begin
          state  <= st_idle;
          o_busy <= 1'b0;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // operand capture; low word sits at the lower address
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      opnd <= '0;
    end else if (i_ce) begin
      if (accept) opnd <= {16'h0, i_cmd.konst};
      else if (state == st_fetch_lo) opnd <= {16'h0, i_mem_rdata};
      else if (state == st_fetch_hi) opnd[ACC_W-1:WORD_W] <= i_mem_rdata; // RULE_02
    end
  end

  // arithmetic; the divider is combinational, trading area for a short, fixed latency
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      res_word <= '0;
      conv_bin <= '0;
      rem_bin  <= '0;
      bad_bcd  <= 1'b0;
      div_zero <= 1'b0;
    end else if (i_ce && state == st_calc) begin
      bad_bcd  <= !bcd_ok; // RULE_12
      div_zero <= is_div && (b_bin == '0); // RULE_13
      if (op_r == op_inc_bin) res_word <= WORD_W'(opnd[WORD_W-1:0] + 16'h1); // RULE_09
      else res_word <= bcd_step(opnd[WORD_W-1:0], op_r == op_dec_bcd); // RULE_07 RULE_08
      if (is_div && b_bin != '0) begin
        conv_bin <= PROD_W'(a_bin / b_bin); // RULE_04 RULE_05
        rem_bin  <= BIN_W'(a_bin % b_bin);
      end else begin
        conv_bin <= PROD_W'(a_bin) * PROD_W'(b_bin); // RULE_01 RULE_02
        rem_bin  <= '0;
      end
    end
  end

  // product or quotient back to decimal
  bin_to_bcd #(.BITS(PROD_W), .DIGITS(PROD_DIGITS)) u_wide_conv (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_start (conv_start),
    .i_bin   (conv_bin),
    .o_done  (wide_done),
    .o_bcd   (prod_bcd)
  );

  // remainder back to decimal, finishes before the wide one
  bin_to_bcd #(.BITS(BIN_W), .DIGITS(ACC_DIGITS)) u_rem_conv (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_start (conv_start),
    .i_bin   (rem_bin),
    .o_done  (),
    .o_bcd   (rem_bcd)
  );

  // accumulator and stack top
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_acc        <= ACC_RESET;
      o_stack_top  <= '0;
      o_stack_push <= 1'b0;
    end else if (i_ce) begin
      o_stack_push <= 1'b0;
      if (state == st_idle && i_acc_load) begin
        o_acc <= i_acc_wdata;
      end else if (fin && ok_result && !is_mem_op) begin
        o_acc <= prod_bcd[ACC_W-1:0]; // RULE_01 RULE_03 RULE_04
        if (op_r != op_mul_word) begin
          o_stack_push <= 1'b1; // RULE_03 RULE_04 RULE_05
          o_stack_top  <= (op_r == op_mul_long) ? prod_bcd[2*ACC_W-1:ACC_W] : rem_bcd;
        end
      end
    end
  end

  // flags recomputed only by instructions that own them, held otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_flags <= '0;
    end else if (i_ce && fin) begin // RULE_14 RULE_15
      if (bad_bcd) begin
        o_flags.inv <= 1'b1; // RULE_12
        if (is_div) o_flags.ovf <= 1'b0;
      end else if (div_zero) begin
        o_flags.ovf <= 1'b1; // RULE_13
        o_flags.inv <= 1'b0;
      end else if (is_mem_op) begin
        o_flags.zero <= (res_word == '0); // RULE_10
        if (op_r != op_inc_bin) o_flags.inv <= 1'b0; // RULE_17
      end else begin
        o_flags.zero <= (prod_bcd[ACC_W-1:0] == '0); // RULE_10
        o_flags.neg  <= prod_bcd[ACC_W-1]; // RULE_11
        o_flags.inv  <= 1'b0;
        if (is_div) o_flags.ovf <= 1'b0;
      end
    end
  end

  // write-back; a bad operand leaves memory untouched
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_wdata <= '0;
    end else if (i_ce) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      if (accept && i_cmd.rung &&
          !(i_cmd.use_const && (i_cmd.op == op_mul_word || i_cmd.op == op_div_word))) begin
        o_mem_rd   <= 1'b1;
        o_mem_addr <= i_cmd.addr;
      end else if (state == st_fetch_lo && is_long) begin
        o_mem_rd   <= 1'b1;
        o_mem_addr <= WORD_W'(addr_r + 16'h1); // RULE_02 RULE_05
      end else if (fin && is_mem_op && !bad_bcd) begin
        o_mem_wr    <= 1'b1; // RULE_07 RULE_08 RULE_09
        o_mem_addr  <= addr_r;
        o_mem_wdata <= res_word;
      end
    end
  end

  // sticky events, cleared by a status read; a new event wins over the clear
  always_comb begin
    next_status = status;
    next_mask   = mask;
    if (i_reg.rd && i_reg.addr == REG_STATUS) next_status = '0;
    if (i_reg.wr && i_reg.addr == REG_MASK) next_mask = i_reg.wdata[EV_W-1:0];
    if (fin || (accept && !i_cmd.rung)) next_status[EV_DONE] = 1'b1;
    if (fin && bad_bcd && op_r != op_inc_bin) next_status[EV_INV] = 1'b1;
    if (fin && !bad_bcd && div_zero) next_status[EV_OVF] = 1'b1;
  end

  // status, mask, done pulse and interrupt level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status <= STATUS_RESET;
      mask   <= MASK_RESET;
      o_done <= 1'b0;
      o_irq  <= 1'b0;
    end else if (i_ce) begin
      status <= next_status;
      mask   <= next_mask;
      o_done <= fin || (accept && !i_cmd.rung); // RULE_16
      o_irq  <= |(next_status & next_mask);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= '0;
    end else if (i_ce) begin
      o_reg_rdata <= '0;
      if (i_reg.rd) begin
        case (i_reg.addr)
          REG_STATUS: o_reg_rdata <= REG_DW'(status);
          REG_MASK:   o_reg_rdata <= REG_DW'(mask);
          REG_FLAGS:  o_reg_rdata <= REG_DW'(o_flags);
          REG_ACC:    o_reg_rdata <= o_acc;
          default:    o_reg_rdata <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_no_rung;
    (accept && i_ce && !i_cmd.rung && !i_acc_load) |=>
      (o_done && $stable(o_acc) && $stable(o_flags) && !o_mem_wr && !o_mem_rd);
  endproperty
  a_no_rung: assert property (p_no_rung) else $error("disabled rung changed state"); // RULE_16

  property p_long_fetch;
    (i_ce && state == st_fetch_lo && is_long) |=>
      (o_mem_rd && o_mem_addr == WORD_W'($past(o_mem_addr) + 16'h1));
  endproperty
  a_long_fetch: assert property (p_long_fetch) else $error("second word not fetched"); // RULE_02

  property p_div_long_mem;
    (accept && i_ce && i_cmd.rung && i_cmd.op == op_div_long) |=>
      (o_mem_rd && state == st_fetch_lo);
  endproperty
  a_div_long_mem: assert property (p_div_long_mem) else $error("long divide skipped fetch"); // RULE_06

  property p_write_addr;
    o_mem_wr |-> (o_mem_addr == addr_r && is_mem_op && o_done);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("write-back misplaced"); // RULE_07

  property p_inc_bin_flags;
    (o_done && ran && op_r == op_inc_bin) |->
      (o_flags.inv == $past(o_flags.inv) && o_flags.neg == $past(o_flags.neg) &&
       o_flags.ovf == $past(o_flags.ovf) && o_mem_wr);
  endproperty
  a_inc_bin_flags: assert property (p_inc_bin_flags) else $error("binary inc touched flags"); // RULE_17

  property p_zero_word;
    (o_done && ran && is_mem_op && !bad_bcd) |-> (o_flags.zero == (o_mem_wdata == '0));
  endproperty
  a_zero_word: assert property (p_zero_word) else $error("zero flag wrong on word op"); // RULE_10

  property p_invalid;
    (o_done && ran && bad_bcd) |-> (o_flags.inv && !o_mem_wr && $stable(o_acc));
  endproperty
  a_invalid: assert property (p_invalid) else $error("bad digit not flagged"); // RULE_12

  property p_div_ovf;
    (o_done && ran && is_div && !bad_bcd && div_zero) |-> (o_flags.ovf && !o_stack_push);
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("divide overflow not flagged"); // RULE_13

  property p_acc_flags;
    (o_done && ran && !is_mem_op && ok_result) |->
      (o_flags.neg == o_acc[ACC_W-1] && o_flags.zero == (o_acc == '0) && !o_flags.inv);
  endproperty
  a_acc_flags: assert property (p_acc_flags) else $error("acc flags mismatch"); // RULE_11

  property p_push;
    (o_done && ran && !is_mem_op && ok_result) |-> (o_stack_push == (op_r != op_mul_word));
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong"); // RULE_03

  property p_irq;
    o_irq == |(status & mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");

  c_mul_long: cover property (o_done && ran && op_r == op_mul_long && ok_result);
  c_div_ovf:  cover property (o_done && ran && div_zero);
  c_dec_wrap: cover property (o_mem_wr && op_r == op_dec_bcd && o_mem_wdata == 16'h9999);
  c_irq:      cover property (o_irq && status[EV_INV]);
endmodule : bcd_mul_div_incdec_unit
`default_nettype wire

/* sim/word_mem_model.sv */
`default_nettype none
module word_mem_model (
  // clock
  input  wire logic        i_clk,
  // memory port
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic [15:0]      o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  // plain always so the bench may preload words
  always @(posedge i_clk) begin
    if (i_wr) mem[i_addr[3:0]] <= i_wdata;
  end
  // the unit captures while its read strobe stands; inverted otherwise to catch stray sampling
  assign o_rdata = i_rd ? mem[i_addr[3:0]] : ~mem[i_addr[3:0]];
endmodule : word_mem_model
`default_nettype wire

/* sim/test_bcd_mul_div_incdec_unit.sv */
`default_nettype none
module test_bcd_mul_div_incdec_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import bcd_unit_pkg::*;
  logic        i_clk   = 1'b0;
  logic        i_rst_n = 1'b0;
  cmd_t        cmd     = '0;
  logic        acc_ld  = 1'b0;
  logic        ce      = 1'b1;
  logic [31:0] acc_wd  = 32'h0;
  reg_req_t    rq      = '0;
  logic        busy, done, push, mrd, mwr, irq;
  logic [31:0] acc, stk, rdat;
  logic [15:0] maddr, mwd, mdat;
  flags_t      fl;
  int          err_count = 0;
  int          n_checks  = 0;

  // 10 MHz clock
  always #50 i_clk = ~i_clk;

  bcd_mul_div_incdec_unit dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_cmd(cmd),
    .o_busy(busy), .o_done(done), .i_acc_load(acc_ld), .i_acc_wdata(acc_wd), .o_acc(acc),
    .o_stack_top(stk), .o_stack_push(push), .o_flags(fl), .o_mem_rd(mrd), .o_mem_wr(mwr),
    .o_mem_addr(maddr), .o_mem_wdata(mwd), .i_mem_rdata(mdat), .i_reg(rq),
    .o_reg_rdata(rdat), .o_irq(irq));

  word_mem_model mem_u (.i_clk(i_clk), .i_rd(mrd), .i_wr(mwr), .i_addr(maddr),
    .i_wdata(mwd), .o_rdata(mdat));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one request pulse, then a bounded wait for the done pulse
  task automatic run(input op_t op, input logic rung, input logic uc, input logic [15:0] k,
                     input logic [15:0] a);
    int i;
    @(posedge i_clk);
    cmd <= '{valid: 1'b1, rung: rung, op: op, use_const: uc, konst: k, addr: a};
    for (i = 0; i < 200; i++) begin
      @(posedge i_clk);
      cmd.valid <= 1'b0;
      #1;
      if (i == 0) chk(32'({busy, mrd}), 32'({rung, rung & ~uc}));
      if (done === 1'b1) break;
    end
    if (i == 200) begin
      err_count++;
      end_of_test();
    end
  endtask : run

  // write-back seen in the done cycle
  task automatic wb(input logic [15:0] a, input logic [15:0] d);
    chk(32'(mwr), 32'h1);
    chk(32'(maddr), 32'(a));
    chk(32'(mwd), 32'(d));
  endtask : wb

  task automatic ld(input logic [31:0] v);
    @(posedge i_clk);
    acc_ld <= 1'b1;
    acc_wd <= v;
    @(posedge i_clk);
    acc_ld <= 1'b0;
  endtask : ld

  task automatic reg_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rq <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(posedge i_clk);
    rq <= '0;
    #1;
    if (!wr) chk(rdat, d);
  endtask : reg_xfer

  task automatic t_reset();
    chk(acc, 32'h0);
    chk(32'(fl), 32'h0);
    reg_xfer(1'b0, REG_MASK, 32'h0);
    reg_xfer(1'b0, REG_STATUS, 32'h0);
    $display("reset values done");
  endtask : t_reset

  task automatic t_incdec();
    run(op_inc_bcd, 1'b1, 1'b0, 16'h0, 16'h1);
    wb(16'h1, 16'h1000);
    run(op_dec_bcd, 1'b1, 1'b0, 16'h0, 16'h2);
    wb(16'h2, 16'h9999);
    run(op_dec_bcd, 1'b1, 1'b0, 16'h0, 16'h3);
    wb(16'h3, 16'h0);
    chk(32'(fl), 32'h1);
    $display("decimal step done");
  endtask : t_incdec

  task automatic t_bin();
    run(op_inc_bin, 1'b1, 1'b0, 16'h0, 16'h4);
    wb(16'h4, 16'h0);
    run(op_inc_bcd, 1'b1, 1'b0, 16'h0, 16'h5);
    chk(32'(mwr), 32'h0);
    chk(32'(fl), 32'h5);
    run(op_inc_bin, 1'b1, 1'b0, 16'h0, 16'h6);
    wb(16'h6, 16'h001a);
    chk(32'(fl), 32'h4);
    $display("binary step done");
  endtask : t_bin

  task automatic t_mul();
    ld(32'h5555_9999);
    run(op_mul_word, 1'b1, 1'b1, 16'h9999, 16'h0);
    chk(acc, 32'h9998_0001);
    chk(32'(fl), 32'h2);
    ld(32'h5000_0000);
    run(op_mul_long, 1'b1, 1'b0, 16'h0, 16'h8);
    chk(acc, 32'h0);
    chk({31'h0, push}, 32'h1);
    chk(stk, 32'h0617_2839);
    chk(32'(fl), 32'h1);
    $display("multiply done");
  endtask : t_mul

  task automatic t_div();
    ld(32'h0000_0100);
    run(op_div_word, 1'b1, 1'b1, 16'h0007, 16'h0);
    chk(acc, 32'h14);
    chk(stk, 32'h2);
    ld(32'h1234_5678);
    run(op_div_long, 1'b1, 1'b0, 16'h0, 16'ha);
    chk(acc, 32'h1234);
    chk(stk, 32'h5678);
    run(op_div_word, 1'b1, 1'b1, 16'h0, 16'h0);
    chk(acc, 32'h1234);
    chk(32'(fl), 32'h8);
    $display("divide done");
  endtask : t_div

  task automatic t_rung();
    run(op_inc_bcd, 1'b0, 1'b0, 16'h0, 16'h1);
    chk(32'(mwr), 32'h0);
    chk(acc, 32'h1234);
    chk(32'(fl), 32'h8);
    $display("rung false done");
  endtask : t_rung

  // enable low freezes the unit, so a load offered then is lost
  task automatic t_freeze();
    @(posedge i_clk);
    ce     <= 1'b0;
    acc_ld <= 1'b1;
    acc_wd <= 32'h0;
    repeat (2) @(posedge i_clk);
    ce     <= 1'b1;
    acc_ld <= 1'b0;
    #1;
    chk(acc, 32'h1234);
    $display("clock enable done");
  endtask : t_freeze

  // every event so far is pending; masking done alone must raise the line
  task automatic t_irq();
    reg_xfer(1'b1, REG_MASK, 32'h1);
    @(posedge i_clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    reg_xfer(1'b0, REG_STATUS, 32'h7);
    @(posedge i_clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    reg_xfer(1'b0, REG_MASK, 32'h1);
    reg_xfer(1'b0, REG_FLAGS, 32'h8);
    reg_xfer(1'b0, REG_ACC, 32'h1234);
    reg_xfer(1'b0, 4'h2, 32'h0);
    $display("interrupt done");
  endtask : t_irq

  // preload operands, reset, then the scenarios
  initial begin
    mem_u.mem[1]  = 16'h0999;
    mem_u.mem[2]  = 16'h0000;
    mem_u.mem[3]  = 16'h0001;
    mem_u.mem[4]  = 16'hffff;
    mem_u.mem[5]  = 16'h00a0;
    mem_u.mem[6]  = 16'h0019;
    mem_u.mem[8]  = 16'h5678;
    mem_u.mem[9]  = 16'h1234;
    mem_u.mem[10] = 16'h0000;
    mem_u.mem[11] = 16'h0001;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    t_reset();
    t_incdec();
    t_bin();
    t_mul();
    t_div();
    t_rung();
    t_freeze();
    t_irq();
    end_of_test();
  end
endmodule : test_bcd_mul_div_incdec_unit
`default_nettype wire
